// ===== rtl/sac_consts.svh
/*
  Named offsets, bit positions, reset values and timing counts of the converter control.
  Assumes inclusion by bare name from rtl files.
*/
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// Register indexes; byte address is four times the index
`define SAC_IDX_PCFG 8'hae
`define SAC_IDX_MODE 8'hb1
`define SAC_IDX_RESH 8'hb2
`define SAC_IDX_CKR 8'hb3
`define SAC_IDX_IRQ 8'hb4

// Mode register fields
`define SAC_M_EN 7
`define SAC_M_GO 6
`define SAC_M_DONE 5
`define SAC_M_GATE 4
`define SAC_M_REF 3
`define SAC_M_SEL_HI 2
`define SAC_MODE_RST 8'h20

// Clock and resolution register fields
`define SAC_C_4V 7
`define SAC_C_CKS1 6
`define SAC_C_RES 5
`define SAC_C_CKS0 4

// Interrupt register fields
`define SAC_I_FLAG 0
`define SAC_I_EN 1

// Divider factors per select code
`define SAC_DIV_00 5'h10
`define SAC_DIV_01 5'h08
`define SAC_DIV_10 5'h01
`define SAC_DIV_11 5'h02

// Conversion length in quarter-rate periods, and converter ticks per period
`define SAC_PER_12 7'h10
`define SAC_PER_8 7'h0c
`define SAC_QUARTER 7'h04

`endif

// ===== rtl/sac_pkg.sv
/*
  Types and shared decoding for the converter control.
  Assumes the constants header is on the include path.
*/
`include "sac_consts.svh"

package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;

  typedef logic [1:0] sac_cks_t;

  function automatic logic [4:0] sac_div_factor(input sac_cks_t cks);
    logic [4:0] f;
    f = `SAC_DIV_00;
    unique case (cks)
      2'h0: f = `SAC_DIV_00;
      2'h1: f = `SAC_DIV_01;
      2'h2: f = `SAC_DIV_10;
      2'h3: f = `SAC_DIV_11;
    endcase
    return f;
  endfunction : sac_div_factor
endpackage : sac_pkg

// ===== rtl/sac_clk_div.sv
/*
  Converter clock divider: one-cycle tick at the selected fraction of sys_clk.
  Assumes run is low between conversions so that each conversion starts aligned.
*/
`timescale 1ns/100ps
`include "sac_consts.svh"

module sac_clk_div (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  input wire sac_pkg::sac_cks_t cks,
  output logic tick
);
  import sac_pkg::*;

  logic [4:0] cnt_q;
  logic [4:0] lim;

  assign lim = sac_div_factor(cks) - 5'h01;
  assign tick = run && (cnt_q == lim);

  // Restarting at each conversion keeps the length exact for every divider
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 5'h00;
    end else if (!run || tick) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule : sac_clk_div

// ===== rtl/sac_top.sv
/*
  Converter control: Avalon-MM register slave, start/done sequencing, channel
  gating, resolution, reference and pin configuration, and completion interrupt.
  Assumes the analog core presents its result on core_result by completion.
*/
//Contract
//- 12-bit: sixteen quarter-rate periods, start to done
//- 8-bit: twelve quarter-rate periods, start to done
//- Divider select: 16, 8, 1, 2
//- Resolution bit 5: 0 eight, 1 twelve
//- Input codes 0-6 pins, 7 op-amp
//- Gate bit connects selected input; set last
//- Enabled start begins; start self-clears at end
//- Done low while busy, high after; resets 1
//- Completion sets done, irq flag, result
//- Flag with enable raises interrupt request
//- Enable bit powers converter; zero disables
//- Reference bit: supply or internal 4V
//- Analog-only bit isolates pin digital path
//- At most one pin connected at once
//- 8-bit fills high byte; 12-bit adds nibble
//- Writing start clears done at once
`timescale 1ns/100ps
`include "sac_consts.svh"

module sac_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [11:0] core_result,
  output logic [7:0] analog_connect_q,
  output logic [6:0] port_analog_only_bits_q,
  output logic converter_power_enable_q,
  output logic high_ref_select_q,
  output logic ref4v_power_q,
  output logic converter_irq_q
);
  import sac_pkg::*;

  sac_state_t state_q;
  logic convert_go_q;
  logic done_q;
  logic channel_gate_enable_q;
  logic [2:0] input_select_q;
  sac_cks_t cks_q;
  logic resolution_select_q;
  logic [7:0] result_high_byte_q;
  logic [3:0] result_low_q;
  logic converter_irq_flag_q;
  logic converter_irq_enable_q;
  logic [6:0] tick_cnt_q;
  logic [7:0] idx;
  logic [7:0] wd;
  logic wr_ok;
  logic wr_mode;
  logic wr_ckr;
  logic wr_irq;
  logic start;
  logic abort;
  logic fin;
  logic tick;
  logic [6:0] conv_ticks;
  logic [7:0] rd_mux;

  assign idx = avs_address[9:2];
  assign wd = avs_writedata[7:0];
  // A write lands only at the edge where waitrequest is seen low
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wr_mode = wr_ok && (idx == `SAC_IDX_MODE);
  assign wr_ckr = wr_ok && (idx == `SAC_IDX_CKR);
  assign wr_irq = wr_ok && (idx == `SAC_IDX_IRQ);

  assign start = wr_mode && wd[`SAC_M_EN] && wd[`SAC_M_GO] && (state_q == SAC_IDLE);
  assign abort = wr_mode && !wd[`SAC_M_EN] && (state_q == SAC_CONV);
  assign conv_ticks = resolution_select_q ? 7'(`SAC_PER_12 * `SAC_QUARTER)
                                          : 7'(`SAC_PER_8 * `SAC_QUARTER);
  assign fin = (state_q == SAC_CONV) && tick && (tick_cnt_q == conv_ticks - 7'h01);

  sac_clk_div u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(state_q == SAC_CONV),
    .cks(cks_q),
    .tick(tick)
  );

  // Bus handshake: one wait cycle, then the answer edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      `SAC_IDX_MODE: rd_mux = {converter_power_enable_q, convert_go_q, done_q,
                               channel_gate_enable_q, high_ref_select_q, input_select_q};
      `SAC_IDX_RESH: rd_mux = result_high_byte_q;
      `SAC_IDX_CKR: rd_mux = {ref4v_power_q, cks_q[1], resolution_select_q, cks_q[0],
                              result_low_q};
      `SAC_IDX_IRQ: rd_mux = {6'h00, converter_irq_enable_q, converter_irq_flag_q};
      default: rd_mux = 8'h00; // Write-only config and unmapped words read zero
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_waitrequest && avs_read) begin
      avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // Static configuration fields
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      converter_power_enable_q <= 1'(`SAC_MODE_RST >> `SAC_M_EN);
      channel_gate_enable_q <= 1'b0;
      high_ref_select_q <= 1'b0;
      input_select_q <= 3'h0;
    end else if (wr_mode) begin
      converter_power_enable_q <= wd[`SAC_M_EN];
      channel_gate_enable_q <= wd[`SAC_M_GATE];
      high_ref_select_q <= wd[`SAC_M_REF];
      input_select_q <= wd[`SAC_M_SEL_HI:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref4v_power_q <= 1'b0;
      cks_q <= 2'h0;
      resolution_select_q <= 1'b0;
    end else if (wr_ckr) begin
      ref4v_power_q <= wd[`SAC_C_4V];
      cks_q <= {wd[`SAC_C_CKS1], wd[`SAC_C_CKS0]};
      resolution_select_q <= wd[`SAC_C_RES];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      port_analog_only_bits_q <= 7'h00;
    end else if (wr_ok && (idx == `SAC_IDX_PCFG)) begin
      port_analog_only_bits_q <= wd[6:0];
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SAC_IDLE;
    end else begin
      unique case (state_q)
        SAC_IDLE: begin
          if (start) begin
            state_q <= SAC_CONV;
          end
        end
        SAC_CONV: begin
          if (fin || abort) begin
            state_q <= SAC_IDLE;
          end
        end
        default: state_q <= SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= 7'h00;
    end else if (state_q != SAC_CONV) begin
      tick_cnt_q <= 7'h00;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      convert_go_q <= 1'b0;
    end else if (start) begin
      convert_go_q <= 1'b1;
    end else if (fin || abort) begin
      convert_go_q <= 1'b0;
    end
  end

  // Completion sets done even if software clears it in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'(`SAC_MODE_RST >> `SAC_M_DONE);
    end else if (fin) begin
      done_q <= 1'b1;
    end else if (start) begin
      done_q <= 1'b0;
    end else if (wr_mode && !wd[`SAC_M_GO] && (state_q == SAC_IDLE)) begin
      done_q <= wd[`SAC_M_DONE];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      result_high_byte_q <= 8'h00;
      result_low_q <= 4'h0;
    end else if (fin) begin
      result_high_byte_q <= core_result[11:4];
      if (resolution_select_q) begin
        result_low_q <= core_result[3:0];
      end
    end
  end

  // Only software clears the flag; a completion in the same cycle wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      converter_irq_flag_q <= 1'b0;
      converter_irq_enable_q <= 1'b0;
    end else begin
      if (fin) begin
        converter_irq_flag_q <= 1'b1;
      end else if (wr_irq && !wd[`SAC_I_FLAG]) begin
        converter_irq_flag_q <= 1'b0;
      end
      if (wr_irq) begin
        converter_irq_enable_q <= wd[`SAC_I_EN];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      converter_irq_q <= 1'b0;
    end else begin
      converter_irq_q <= converter_irq_flag_q && converter_irq_enable_q;
    end
  end

  // One switch per source; a single select code keeps them mutually exclusive
  for (genvar g = 0; g < 8; g++) begin : g_conn
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        analog_connect_q[g] <= 1'b0;
      end else begin
        analog_connect_q[g] <= channel_gate_enable_q && (input_select_q == 3'(g));
      end
    end
  end

  // Checking helpers
  logic [15:0] cyc_q;
  logic [15:0] exp_len;

  assign exp_len = 16'(conv_ticks) * 16'(sac_div_factor(cks_q));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_q <= 16'h0000;
    end else if (start) begin
      cyc_q <= 16'h0001;
    end else if (state_q == SAC_CONV) begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end

  property p_conv_len;
    @(posedge sys_clk) disable iff (!nrst)
    fin |-> cyc_q == exp_len;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_busy_done;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q == SAC_CONV) |-> !done_q && convert_go_q;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done high while busy");

  property p_finish;
    @(posedge sys_clk) disable iff (!nrst)
    fin |=> done_q && !convert_go_q && converter_irq_flag_q && (state_q == SAC_IDLE);
  endproperty
  a_finish: assert property (p_finish) else $error("completion effects missing");

  property p_irq;
    @(posedge sys_clk) disable iff (!nrst)
    converter_irq_flag_q && converter_irq_enable_q |=> converter_irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_one_pin;
    @(posedge sys_clk) disable iff (!nrst)
    $onehot0(analog_connect_q) && ($past(channel_gate_enable_q) || analog_connect_q == 8'h00);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("bad input connection");

  property p_disabled_start;
    @(posedge sys_clk) disable iff (!nrst)
    wr_mode && wd[`SAC_M_GO] && !wd[`SAC_M_EN] && (state_q == SAC_IDLE)
      |=> (state_q == SAC_IDLE) && !convert_go_q && $stable(done_q);
  endproperty
  a_disabled_start: assert property (p_disabled_start) else $error("start while off");

  property p_start_clears;
    @(posedge sys_clk) disable iff (!nrst)
    start |=> !done_q ##1 !done_q;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("done not cleared");

  property p_res8;
    @(posedge sys_clk) disable iff (!nrst)
    fin && !resolution_select_q |=> $stable(result_low_q)
      && result_high_byte_q == $past(core_result[11:4]);
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result placement");

  property p_bus;
    @(posedge sys_clk) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing");

  c_fin12: cover property (@(posedge sys_clk) disable iff (!nrst) fin && resolution_select_q);
  c_fin8: cover property (@(posedge sys_clk) disable iff (!nrst) fin && !resolution_select_q);
  c_abort: cover property (@(posedge sys_clk) disable iff (!nrst) abort);
  c_irq: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(converter_irq_q));
endmodule : sac_top

// ===== bench/sac_analog_src.sv
/*
  Analog sources model: a fixed level per input, seen by the core when connected.
  Assumes the connect vector is one-hot or zero.
*/
`timescale 1ns/100ps

module sac_analog_src (
  input wire logic sys_clk,
  input wire logic [7:0] analog_connect_q,
  output logic [11:0] core_result
);
  logic [11:0] noise_q = 12'h000;

  always_ff @(posedge sys_clk) begin
    noise_q <= noise_q + 12'h3b7;
  end

  // Open or shorted inputs give a level that moves every cycle
  always_comb begin
    core_result = noise_q;
    for (int n = 0; n < 8; n++) begin
      if (analog_connect_q == 8'(1 << n)) begin
        core_result = 12'(12'h1a5 + n * 12'h111);
      end
    end
  end
endmodule : sac_analog_src

// ===== bench/test_sac_top.sv
/*
  Testbench of the converter control: register access, selection, timing, results.
  Assumes the analog source model stands on the core side.
*/
`timescale 1ns/100ps
`include "sac_consts.svh"

module test_sac_top;
  localparam logic [9:0] A_PCFG = {`SAC_IDX_PCFG, 2'b00};
  localparam logic [9:0] A_MODE = {`SAC_IDX_MODE, 2'b00};
  localparam logic [9:0] A_RESH = {`SAC_IDX_RESH, 2'b00};
  localparam logic [9:0] A_CKR = {`SAC_IDX_CKR, 2'b00};
  localparam logic [9:0] A_IRQ = {`SAC_IDX_IRQ, 2'b00};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, pwr, rsel, r4v, irq, rf, res, en;
  logic [11:0] core_result, val;
  logic [7:0] conn, rd;
  logic [6:0] iso;
  logic [2:0] ch;
  logic [1:0] cks;
  logic [3:0] lownib = 4'h0;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int t0, td, n;
  int dv[4] = '{16, 8, 1, 2};

  sac_top sac_top_i (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_result(core_result),
    .analog_connect_q(conn), .port_analog_only_bits_q(iso),
    .converter_power_enable_q(pwr), .high_ref_select_q(rsel),
    .ref4v_power_q(r4v), .converter_irq_q(irq));
  sac_analog_src sac_analog_src_i (.sys_clk(sys_clk), .analog_connect_q(conn),
    .core_result(core_result));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  task wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("ERROR at %0t: cycles %0d want %0d", $time, got, exp);
    end
  endtask : chk_n

  // An edge passes first, so back-to-back calls never drive a strobe twice at once
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    chk(rd, exp, what);
  endtask : rd_chk

  initial begin
    repeat (10) @(posedge sys_clk);
    chk({pwr, rsel, r4v, irq, iso[3:0]}, 8'h00, "rst outs");
    nrst <= 1'b1;
    rd_chk(A_MODE, 8'h20, "mode rst");
    rd_chk(A_CKR, 8'h00, "ckr rst");
    rd_chk(10'h3fc, 8'h00, "unmapped");
    bus(1'b1, A_PCFG, 8'hff);
    rd_chk(A_PCFG, 8'h00, "pcfg wo");
    chk({1'b0, iso}, 8'h7f, "iso");
    avs_byteenable <= 4'he;
    bus(1'b1, A_PCFG, 8'h00);
    avs_byteenable <= 4'hf;
    @(posedge sys_clk);
    chk({1'b0, iso}, 8'h7f, "be0");
    bus(1'b1, A_MODE, 8'h60);
    rd_chk(A_MODE, 8'h20, "go off");
    chk({7'h00, pwr}, 8'h00, "pwr off");
    for (int c = 0; c < 8; c++) begin
      // Switches register one cycle after the gate, so two edges pass
      bus(1'b1, A_MODE, 8'h20 | 8'(c));
      repeat (2) @(posedge sys_clk);
      chk(conn, 8'h00, "ungated");
      bus(1'b1, A_MODE, 8'h30 | 8'(c));
      repeat (2) @(posedge sys_clk);
      chk(conn, 8'h01 << c, "conn");
    end
    // Warm-up after power-on, before any start
    bus(1'b1, A_MODE, 8'ha0);
    repeat (12500) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      ch = 3'(i);
      cks = 2'(i);
      rf = 1'(i);
      res = (i < 4);
      en = (i != 7);
      val = 12'(12'h1a5 + i * 12'h111);
      td = (res ? 64 : 48) * dv[cks];
      bus(1'b1, A_CKR, {rf, cks[1], res, cks[0], 4'h0});
      bus(1'b1, A_IRQ, {6'h00, en, 1'b0});
      bus(1'b1, A_MODE, {4'ha, rf, ch});
      bus(1'b1, A_MODE, {4'hd, rf, ch});
      t0 = cyc;
      rd_chk(A_MODE, {4'hd, rf, ch}, "busy");
      chk({5'h00, pwr, rsel, r4v}, {5'h00, 1'b1, rf, rf}, "pwr ref");
      if (en) begin
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
          @(posedge sys_clk);
          n++;
        end
        // Irq output registers one cycle after done and is seen one edge later
        chk_n(cyc - t0, td + 2);
      end else begin
        repeat (td + 4) @(posedge sys_clk);
        chk({7'h00, irq}, 8'h00, "masked");
      end
      lownib = res ? val[3:0] : lownib;
      rd_chk(A_RESH, val[11:4], "resh");
      rd_chk(A_CKR, {rf, cks[1], res, cks[0], lownib}, "ckr");
      rd_chk(A_MODE, {4'hb, rf, ch}, "done");
      rd_chk(A_IRQ, {6'h00, en, 1'b1}, "flag");
    end
    bus(1'b1, A_IRQ, 8'h03);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01, "irq on");
    bus(1'b1, A_IRQ, 8'h02);
    repeat (2) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h00, "irq clr");
    rd_chk(A_IRQ, 8'h02, "irq reg");
    // Power off in mid-conversion: no completion, done stays low
    bus(1'b1, A_MODE, 8'hd0);
    bus(1'b1, A_MODE, 8'h10);
    repeat (100) @(posedge sys_clk);
    rd_chk(A_MODE, 8'h10, "abort");
    rd_chk(A_IRQ, 8'h02, "no flag");
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR at %0t: timeout", $time);
    wrap_up();
  end
endmodule : test_sac_top
